// [src/bcppm_consts.svh]
// Purpose: Named offsets, fields, codes and reset values of the strap/pin-mux block
// Assumes: Included by bare name from the top module
// Notes:   Definitions only
`ifndef BCPPM_CONSTS_SVH
`define BCPPM_CONSTS_SVH

// Register byte offsets on the bus
`define BCPPM_OFS_IF_CTRL      8'h00
`define BCPPM_OFS_STRAP_STAT   8'h04
`define BCPPM_OFS_USER_STAT    8'h08
`define BCPPM_OFS_MSB          7
`define BCPPM_OFS_LSB          2

// Interface control register layout
`define BCPPM_SEL_W            2
`define BCPPM_UP_SEL_LSB       8
`define BCPPM_CLK_DRV_LSB      10
`define BCPPM_IF_CTRL_RESET    32'h0000_03FF

// User strap status register layout
`define BCPPM_PRESENT_LSB      4

// Strap bit positions
`define BCPPM_STRAP_EEPROM     7
`define BCPPM_STRAP_MOD_DET    9
`define BCPPM_STRAP_PWR_SAVE   11
`define BCPPM_STRAP_TIMEOUT    12

// Interface select codes
`define BCPPM_SEL_RMII         2'h3
`define BCPPM_SEL_MII          2'h1
`define BCPPM_SEL_GPSI         2'h0
`define BCPPM_SEL_UP_MII       2'h3

// Bus encodings
`define BCPPM_HTRANS_NONSEQ_B  1
`define BCPPM_HRESP_OKAY       1'h0
`endif

// [src/bcppm_pkg.sv]
// Purpose: Types shared by the strap capture and pin-mux logic
// Assumes: Nothing is imported; users write bcppm_pkg::name
// Notes:   Pad and MAC groups travel as packed structs
package bcppm_pkg;

    // Capture sequence, Gray coded
    typedef enum logic [1:0] {
        CAP_WAIT = 2'h0,
        CAP_HELD = 2'h1
    } bcppm_cap_t;

    // Resolved media interface of one port
    typedef enum logic [1:0] {
        MODE_NONE = 2'h0,
        MODE_RMII = 2'h1,
        MODE_MII  = 2'h3,
        MODE_GPSI = 2'h2
    } bcppm_mode_t;

    // Access port pins seen by the device
    typedef struct packed {
        logic [3:0] rxd;
        logic       crs_dv;
        logic       col;
        logic       txclk;
        logic       rxclk;
        logic       txen;
    } bcppm_acc_in_t;

    // Access port pin drives and pull controls
    typedef struct packed {
        logic [3:0] txd;
        logic       txen;
        logic       txen_oe;
        logic       txclk_o;
        logic       txclk_oe;
        logic       rxclk_o;
        logic       rxclk_oe;
        logic [3:0] pu_rxd;
        logic       pu_crs_dv;
        logic       pu_txclk;
        logic       pu_rxclk;
        logic       pd_col;
    } bcppm_acc_out_t;

    // Uplink pins seen by the device
    typedef struct packed {
        logic [3:0] rxd;
        logic       rxdv;
        logic       crs;
        logic       col;
        logic       rxclk;
        logic       ref_clk;
        logic       tx_clock;
    } bcppm_up_in_t;

    // Uplink pin drives and pull controls
    typedef struct packed {
        logic [3:0] txd;
        logic       txen;
        logic       txen_oe;
        logic       rxclk_o;
        logic       rxclk_oe;
        logic [3:0] pu_rxd;
        logic       pu_rxdv;
        logic       pu_rxclk;
        logic       pu_txen;
        logic       pu_ref_clk;
        logic       pu_tx_clock;
        logic       pd_crs;
        logic       pd_col;
    } bcppm_up_out_t;

    // Receive side handed to a MAC
    typedef struct packed {
        logic [3:0] rxd;
        logic       dv;
        logic       crs;
        logic       col;
        logic       txclk;
        logic       rxclk;
    } bcppm_mac_rx_t;

    // Transmit side coming from a MAC
    typedef struct packed {
        logic [3:0] txd;
        logic       txen;
        logic       clk_out;
    } bcppm_mac_tx_t;

endpackage

// [src/bcppm_top.sv]
// Purpose: Captures reset-time straps and maps port pins to the selected media interface
// Assumes: One clock, all inputs synchronous, AHB-Lite register access
// Notes:   All outputs are registered; ce low freezes every flip-flop
`timescale 1ns/100ps
`include "bcppm_consts.svh"

// Behaviour
// - Sample all straps once after reset
// - Strap high means no EEPROM fitted
// - Module detect strap enables presence detection
// - Power saving strap enables MAC power saving
// - Timeout strap enables non-idle state monitor
// - Transmit-enable pins captured, readable by software
// - Port code 11 RMII, 01 MII, 00 GPSI
// - RMII uses two data bits and CRS_DV
// - MII four bits; GPSI bit zero only
// - Mode-dependent pulls; no module pulls inputs up
// - Uplink supports MII only, code 11
module bcppm_top #(
    parameter int NUM_PORTS = 4
) (
    // Clock, reset, enable
    input  wire logic                                     ref_clk,
    input  wire logic                                     rst_n,
    input  wire logic                                     ce,
    // AHB-Lite slave
    input  wire logic                                     hsel,
    input  wire logic [31:0]                              haddr,
    input  wire logic [1:0]                               htrans,
    input  wire logic                                     hwrite,
    input  wire logic [2:0]                               hsize,
    input  wire logic [31:0]                              hwdata,
    input  wire logic                                     hready,
    output logic      [31:0]                              hrdata,
    output logic                                          hreadyout,
    output logic                                          hresp,
    // Strap pins and module presence
    input  wire logic [15:0]                              strap_bus,
    input  wire logic [NUM_PORTS:0]                       module_present,
    // Access port pads
    input  wire bcppm_pkg::bcppm_acc_in_t [NUM_PORTS-1:0]  acc_pad_i,
    output bcppm_pkg::bcppm_acc_out_t     [NUM_PORTS-1:0]  acc_pad_o,
    // Access port MAC side
    input  wire bcppm_pkg::bcppm_mac_tx_t [NUM_PORTS-1:0]  acc_mac_tx,
    output bcppm_pkg::bcppm_mac_rx_t      [NUM_PORTS-1:0]  acc_mac_rx,
    // Uplink pads and MAC side
    input  wire bcppm_pkg::bcppm_up_in_t                   up_pad_i,
    output bcppm_pkg::bcppm_up_out_t                       up_pad_o,
    input  wire bcppm_pkg::bcppm_mac_tx_t                  up_mac_tx,
    output bcppm_pkg::bcppm_mac_rx_t                       up_mac_rx,
    output logic                                          up_ref_clk_o,
    // Strap-derived enables
    output logic                                          eeprom_load_en,
    output logic                                          module_detect_en,
    output logic                                          power_save_en,
    output logic                                          timeout_mon_en,
    output logic                                          straps_valid
);

    // Capture state and held strap values
    bcppm_pkg::bcppm_cap_t          cap_state_reg;
    logic [15:0]                    strap_reg;
    logic [NUM_PORTS-1:0]           port_tx_enable_user_strap;
    // Interface control register and its select fields
    logic [31:0]                    if_ctrl_reg;
    // Bus data phase bookkeeping
    logic                           wr_pend_reg;
    logic [`BCPPM_OFS_MSB:0]        wr_ofs_reg;
    // Resolved mode per port and uplink
    bcppm_pkg::bcppm_mode_t [NUM_PORTS-1:0] acc_mode;
    bcppm_pkg::bcppm_mode_t                 up_mode;
    logic                           addr_take;

    // Maps a select code and presence to a mode; the uplink knows only MII
    function automatic bcppm_pkg::bcppm_mode_t mode_of(input logic [1:0] sel,
                                                       input logic       present,
                                                       input logic       uplink);
        bcppm_pkg::bcppm_mode_t m;
        m = bcppm_pkg::MODE_NONE;
        if (present && uplink) begin
            if (sel == `BCPPM_SEL_UP_MII) begin
                m = bcppm_pkg::MODE_MII;
            end
        end else if (present) begin
            case (sel)
                `BCPPM_SEL_RMII: m = bcppm_pkg::MODE_RMII;
                `BCPPM_SEL_MII:  m = bcppm_pkg::MODE_MII;
                `BCPPM_SEL_GPSI: m = bcppm_pkg::MODE_GPSI;
                default:         m = bcppm_pkg::MODE_NONE;
            endcase
        end
        return m;
    endfunction

    // Presence counts only while detection is enabled
    function automatic logic seen(input logic det_en, input logic pin);
        return !det_en || pin;
    endfunction

    // Strap capture: first enabled edge after reset, then frozen
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_state_reg             <= bcppm_pkg::CAP_WAIT;
            strap_reg                 <= 16'h0000;
            port_tx_enable_user_strap <= '0;
            eeprom_load_en            <= 1'h0;
            module_detect_en          <= 1'h0;
            power_save_en             <= 1'h0;
            timeout_mon_en            <= 1'h0;
            straps_valid              <= 1'h0;
        end else if (ce) begin
            case (cap_state_reg)
                bcppm_pkg::CAP_WAIT: begin
                    // Pins still undriven here, so the resistors set the level
                    strap_reg        <= strap_bus;
                    for (int p = 0; p < NUM_PORTS; p++) begin
                        port_tx_enable_user_strap[p] <= acc_pad_i[p].txen;
                    end
                    eeprom_load_en   <= !strap_bus[`BCPPM_STRAP_EEPROM];
                    module_detect_en <= strap_bus[`BCPPM_STRAP_MOD_DET];
                    power_save_en    <= strap_bus[`BCPPM_STRAP_PWR_SAVE];
                    timeout_mon_en   <= strap_bus[`BCPPM_STRAP_TIMEOUT];
                    straps_valid     <= 1'h1;
                    cap_state_reg    <= bcppm_pkg::CAP_HELD;
                end
                bcppm_pkg::CAP_HELD: begin
                    // Held until reset; later pin activity is ignored
                    cap_state_reg <= bcppm_pkg::CAP_HELD;
                end
                default: begin
                    cap_state_reg <= bcppm_pkg::CAP_WAIT;
                end
            endcase
        end
    end

    // Address phase accepted on the bus
    assign addr_take = hsel && hready && htrans[`BCPPM_HTRANS_NONSEQ_B];

    // Mode resolution for every port
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            acc_mode[p] = mode_of(if_ctrl_reg[p*`BCPPM_SEL_W +: `BCPPM_SEL_W],
                                  seen(module_detect_en, module_present[p]), 1'h0);
        end
        up_mode = mode_of(if_ctrl_reg[`BCPPM_UP_SEL_LSB +: `BCPPM_SEL_W],
                          seen(module_detect_en, module_present[NUM_PORTS]), 1'h1);
    end

    // Bus front end: zero wait states, always OKAY
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout   <= 1'h0;
            hresp       <= `BCPPM_HRESP_OKAY;
            wr_pend_reg <= 1'h0;
            wr_ofs_reg  <= '0;
        end else if (ce) begin
            hreadyout   <= 1'h1;
            hresp       <= `BCPPM_HRESP_OKAY;
            // Writes land in the data phase, when hwdata is valid
            wr_pend_reg <= addr_take && hwrite;
            wr_ofs_reg  <= haddr[`BCPPM_OFS_MSB:0];
        end
    end

    // Read data staged at the address phase so it stands in the data phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (ce) begin
            hrdata <= 32'h0000_0000;
            if (addr_take && !hwrite) begin
                case (haddr[`BCPPM_OFS_MSB:0])
                    `BCPPM_OFS_IF_CTRL:    hrdata <= if_ctrl_reg;
                    `BCPPM_OFS_STRAP_STAT: hrdata <= {16'h0000, strap_reg};
                    `BCPPM_OFS_USER_STAT: begin
                        // User straps and presence, upper bits zero
                        hrdata[NUM_PORTS-1:0] <= port_tx_enable_user_strap;
                        hrdata[`BCPPM_PRESENT_LSB +: NUM_PORTS+1] <= module_present;
                    end
                    default:               hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Interface control register, written in the data phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            if_ctrl_reg <= `BCPPM_IF_CTRL_RESET;
        end else if (ce && wr_pend_reg && wr_ofs_reg == `BCPPM_OFS_IF_CTRL) begin
            // Only select and clock-drive fields are writable
            if_ctrl_reg <= {17'h00000,
                            hwdata[`BCPPM_CLK_DRV_LSB +: NUM_PORTS+1],
                            hwdata[`BCPPM_CLK_DRV_LSB-1:0]};
        end
    end

    // Access port pad and MAC mapping
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_pad_o  <= '0;
            acc_mac_rx <= '0;
        end else if (ce) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                // Defaults: nothing pulled, outputs low
                acc_pad_o[p]  <= '0;
                acc_mac_rx[p] <= '0;
                // Transmit enable doubles as strap, so released until captured
                acc_pad_o[p].txen_oe <= (cap_state_reg == bcppm_pkg::CAP_HELD);
                case (acc_mode[p])
                    bcppm_pkg::MODE_RMII: begin
                        acc_pad_o[p].txd       <= {2'h0, acc_mac_tx[p].txd[1:0]};
                        acc_pad_o[p].txen      <= acc_mac_tx[p].txen;
                        acc_pad_o[p].pu_rxd    <= 4'hC;
                        acc_pad_o[p].pu_txclk  <= 1'h1;
                        acc_pad_o[p].pu_rxclk  <= 1'h1;
                        acc_pad_o[p].pd_col    <= 1'h1;
                        acc_mac_rx[p].rxd      <= {2'h0, acc_pad_i[p].rxd[1:0]};
                        acc_mac_rx[p].dv       <= acc_pad_i[p].crs_dv;
                        acc_mac_rx[p].crs      <= acc_pad_i[p].crs_dv;
                    end
                    bcppm_pkg::MODE_MII: begin
                        acc_pad_o[p].txd       <= acc_mac_tx[p].txd;
                        acc_pad_o[p].txen      <= acc_mac_tx[p].txen;
                        acc_pad_o[p].txclk_o   <= acc_mac_tx[p].clk_out;
                        acc_pad_o[p].rxclk_o   <= acc_mac_tx[p].clk_out;
                        acc_pad_o[p].txclk_oe  <= if_ctrl_reg[`BCPPM_CLK_DRV_LSB + p];
                        acc_pad_o[p].rxclk_oe  <= if_ctrl_reg[`BCPPM_CLK_DRV_LSB + p];
                        acc_mac_rx[p].rxd      <= acc_pad_i[p].rxd;
                        acc_mac_rx[p].dv       <= acc_pad_i[p].crs_dv;
                        acc_mac_rx[p].crs      <= acc_pad_i[p].crs_dv;
                        acc_mac_rx[p].col      <= acc_pad_i[p].col;
                        acc_mac_rx[p].txclk    <= acc_pad_i[p].txclk;
                        acc_mac_rx[p].rxclk    <= acc_pad_i[p].rxclk;
                    end
                    bcppm_pkg::MODE_GPSI: begin
                        acc_pad_o[p].txd       <= {3'h0, acc_mac_tx[p].txd[0]};
                        acc_pad_o[p].txen      <= acc_mac_tx[p].txen;
                        acc_pad_o[p].txclk_o   <= acc_mac_tx[p].clk_out;
                        acc_pad_o[p].rxclk_o   <= acc_mac_tx[p].clk_out;
                        acc_pad_o[p].txclk_oe  <= if_ctrl_reg[`BCPPM_CLK_DRV_LSB + p];
                        acc_pad_o[p].rxclk_oe  <= if_ctrl_reg[`BCPPM_CLK_DRV_LSB + p];
                        acc_pad_o[p].pu_rxd    <= 4'hE;
                        acc_mac_rx[p].rxd      <= {3'h0, acc_pad_i[p].rxd[0]};
                        acc_mac_rx[p].crs      <= acc_pad_i[p].crs_dv;
                        acc_mac_rx[p].dv       <= acc_pad_i[p].crs_dv;
                        acc_mac_rx[p].col      <= acc_pad_i[p].col;
                        acc_mac_rx[p].txclk    <= acc_pad_i[p].txclk;
                        acc_mac_rx[p].rxclk    <= acc_pad_i[p].rxclk;
                    end
                    default: begin
                        // No module: inputs up, collision down, txen stays driven, clocks released
                        acc_pad_o[p].pu_rxd    <= 4'hF;
                        acc_pad_o[p].pu_crs_dv <= 1'h1;
                        acc_pad_o[p].pu_txclk  <= 1'h1;
                        acc_pad_o[p].pu_rxclk  <= 1'h1;
                        acc_pad_o[p].pd_col    <= 1'h1;
                    end
                endcase
            end
        end
    end

    // Uplink pad and MAC mapping
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_pad_o     <= '0;
            up_mac_rx    <= '0;
            up_ref_clk_o <= 1'h0;
        end else if (ce) begin
            up_pad_o     <= '0;
            up_mac_rx    <= '0;
            up_ref_clk_o <= 1'h0;
            if (up_mode == bcppm_pkg::MODE_MII) begin
                up_pad_o.txd      <= up_mac_tx.txd;
                up_pad_o.txen     <= up_mac_tx.txen;
                up_pad_o.txen_oe  <= 1'h1;
                up_pad_o.rxclk_o  <= up_mac_tx.clk_out;
                up_pad_o.rxclk_oe <= if_ctrl_reg[`BCPPM_CLK_DRV_LSB + NUM_PORTS];
                up_mac_rx.rxd     <= up_pad_i.rxd;
                up_mac_rx.dv      <= up_pad_i.rxdv;
                up_mac_rx.crs     <= up_pad_i.crs;
                up_mac_rx.col     <= up_pad_i.col;
                up_mac_rx.rxclk   <= up_pad_i.rxclk;
                // Dedicated transmit clock input feeds the MAC transmit side
                up_mac_rx.txclk   <= up_pad_i.tx_clock;
                up_ref_clk_o      <= up_pad_i.ref_clk;
            end else begin
                // Idle uplink: txen released and pulled up, crs and col down
                up_pad_o.pu_rxd      <= 4'hF;
                up_pad_o.pu_rxdv     <= 1'h1;
                up_pad_o.pu_rxclk    <= 1'h1;
                up_pad_o.pu_txen     <= 1'h1;
                up_pad_o.pu_ref_clk  <= 1'h1;
                up_pad_o.pu_tx_clock <= 1'h1;
                up_pad_o.pd_crs      <= 1'h1;
                up_pad_o.pd_col      <= 1'h1;
            end
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Sampled reset keeps the release edge itself, where the flops still reset, out
    sequence cap_edge_s;
        rst_n && ce && cap_state_reg == bcppm_pkg::CAP_WAIT;
    endsequence

    strap_sample_a: assert property (cap_edge_s |=> strap_reg == $past(strap_bus))
        else $error("strap bus not captured");
    eeprom_sel_a: assert property (cap_edge_s |=>
        eeprom_load_en == !$past(strap_bus[`BCPPM_STRAP_EEPROM]))
        else $error("eeprom select wrong");
    mod_detect_a: assert property (cap_edge_s |=>
        module_detect_en == $past(strap_bus[`BCPPM_STRAP_MOD_DET]))
        else $error("module detect enable wrong");
    power_save_a: assert property (cap_edge_s |=>
        power_save_en == $past(strap_bus[`BCPPM_STRAP_PWR_SAVE]))
        else $error("power save enable wrong");
    timeout_en_a: assert property (cap_edge_s |=>
        timeout_mon_en == $past(strap_bus[`BCPPM_STRAP_TIMEOUT]))
        else $error("timeout enable wrong");
    user_read_a: assert property (addr_take && ce && !hwrite
        && haddr[`BCPPM_OFS_MSB:0] == `BCPPM_OFS_USER_STAT
        |=> hrdata[NUM_PORTS-1:0] == port_tx_enable_user_strap)
        else $error("user strap read mismatch");
    rmii_map_a: assert property (rst_n && ce && acc_mode[0] == bcppm_pkg::MODE_RMII |=>
        acc_pad_o[0].pu_rxd == 4'hC && acc_mac_rx[0].rxd[3:2] == 2'h0
        && acc_mac_rx[0].col == 1'h0)
        else $error("rmii mapping wrong");
    gpsi_map_a: assert property (ce && acc_mode[0] == bcppm_pkg::MODE_GPSI |=>
        acc_pad_o[0].txd[3:1] == 3'h0 && acc_mac_rx[0].rxd[3:1] == 3'h0)
        else $error("gpsi mapping wrong");
    no_module_a: assert property (ce && acc_mode[0] == bcppm_pkg::MODE_NONE |=>
        acc_pad_o[0].pu_rxd == 4'hF && acc_pad_o[0].pd_col)
        else $error("no module pulls wrong");
    uplink_sel_a: assert property (ce
        && if_ctrl_reg[`BCPPM_UP_SEL_LSB +: `BCPPM_SEL_W] != `BCPPM_SEL_UP_MII
        |=> up_pad_o.pu_txen && !up_pad_o.txen_oe)
        else $error("uplink active without mii code");
    strap_hold_a: assert property (cap_state_reg == bcppm_pkg::CAP_HELD |=>
        $stable(strap_reg) && $stable(port_tx_enable_user_strap))
        else $error("captured straps changed");
    port_code_a: assert property (module_present[1] && !module_detect_en
        && if_ctrl_reg[3:2] == `BCPPM_SEL_MII |-> acc_mode[1] == bcppm_pkg::MODE_MII)
        else $error("port select decode wrong");

endmodule

// [verif/bcppm_board_model.sv]
// Purpose: Board strap resistors and attached PHY modules
// Assumes: The bench sets the straps before each reset
// Notes:   Receive pins move every cycle, so a sample stale by fewer than 16 cycles never matches
`timescale 1ns/100ps
module bcppm_board_model (
    // Clock and board settings
    input  wire logic                            ref_clk,
    input  wire logic [15:0]                     strap_val,
    input  wire logic [3:0]                      txen_strap,
    input  wire logic [4:0]                      present,
    // Device pads
    input  wire bcppm_pkg::bcppm_acc_out_t [3:0] acc_pad_o,
    output logic      [15:0]                     strap_bus,
    output logic      [4:0]                      module_present,
    output bcppm_pkg::bcppm_acc_in_t      [3:0]  acc_pad_i,
    output bcppm_pkg::bcppm_up_in_t              up_pad_i
);
    logic [7:0] cnt;  // PHY activity pattern
    initial cnt = 8'h00;
    // Receive activity advances every cycle
    always @(posedge ref_clk) begin
        cnt <= cnt + 8'h01;
    end
    // Transmit-enable pin shows the resistor only while the device lets go
    always_comb begin
        strap_bus      = strap_val;
        module_present = present;
        up_pad_i       = {cnt[3:0], cnt[4], cnt[5], cnt[6], cnt[0], cnt[1], cnt[2]};
        for (int p = 0; p < 4; p++) begin
            acc_pad_i[p] = {cnt[3:0], cnt[4], cnt[5], cnt[0], cnt[1],
                            acc_pad_o[p].txen_oe ? acc_pad_o[p].txen : txen_strap[p]};
        end
    end
endmodule

// [verif/bcppm_top_test.sv]
// Purpose: Self-checking bench for strap capture and port pin mux
// Assumes: Zero-wait bus slave; outputs registered one cycle
// Notes:   Bus answers are sampled at the falling edge before use
`timescale 1ns/100ps
module bcppm_top_test;
    logic ref_clk, rst_n, hsel, hwrite, rdy_q;     // Clock, reset, bus control
    logic [1:0]  htrans;                           // Transfer kind
    logic [31:0] haddr, hwdata, hrdata, rd_q, rd;  // Bus data
    logic        hreadyout, hresp;                 // Slave answer
    logic [15:0] strap_bus, strap_val;             // Strap pins and setting
    logic [3:0]  txen_strap;                       // User strap resistors
    logic [4:0]  module_present, present;          // Module presence
    logic        eeprom_load_en, module_detect_en, power_save_en, timeout_mon_en, straps_valid;
    bcppm_pkg::bcppm_acc_in_t  [3:0] acc_pad_i;    // Access pads in
    bcppm_pkg::bcppm_acc_out_t [3:0] acc_pad_o;    // Access pads out
    bcppm_pkg::bcppm_up_in_t         up_pad_i;     // Uplink pads in
    bcppm_pkg::bcppm_up_out_t        up_pad_o;     // Uplink pads out
    bcppm_pkg::bcppm_mac_rx_t  [3:0] acc_mac_rx;   // MAC receive side
    int bad_count = 0;
    int n_compared = 0;

    bcppm_top #(.NUM_PORTS(4)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .strap_bus(strap_bus), .module_present(module_present),
        .acc_pad_i(acc_pad_i), .acc_pad_o(acc_pad_o), .acc_mac_tx('0), .acc_mac_rx(acc_mac_rx),
        .up_pad_i(up_pad_i), .up_pad_o(up_pad_o), .up_mac_tx('0), .up_mac_rx(),
        .up_ref_clk_o(), .eeprom_load_en(eeprom_load_en), .module_detect_en(module_detect_en),
        .power_save_en(power_save_en), .timeout_mon_en(timeout_mon_en),
        .straps_valid(straps_valid));
    bcppm_board_model i_board (.ref_clk(ref_clk), .strap_val(strap_val),
        .txen_strap(txen_strap), .present(present), .acc_pad_o(acc_pad_o),
        .strap_bus(strap_bus), .module_present(module_present), .acc_pad_i(acc_pad_i),
        .up_pad_i(up_pad_i));

    // Clock, 10 ns period
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Settled bus answer, taken half a cycle before each rising edge
    always @(negedge ref_clk) begin
        rdy_q <= hreadyout;
        rd_q  <= hrdata;
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single-word transfer; waits for ready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge ref_clk); while (rdy_q !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (rdy_q !== 1'b1);
        rd = rd_q;
    endtask
    // Reset with new board straps, then check the captured configuration
    task automatic t_straps(input logic [15:0] sv, input logic [3:0] ts, input logic [4:0] pr);
        strap_val  <= sv;
        txen_strap <= ts;
        present    <= pr;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({28'h0, eeprom_load_en, module_detect_en, power_save_en, timeout_mon_en},
            {28'h0, ~sv[7], sv[9], sv[11], sv[12]});
        chk({30'h0, straps_valid, hresp}, 32'h2);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, {16'h0, sv});
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, {23'h0, pr, ts});
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        // Pins now change; captured values must not
        strap_val  <= ~sv;
        txen_strap <= ~ts;
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, {16'h0, sv});
        chk({31'h0, module_detect_en}, {31'h0, sv[9]});
    endtask
    // Every port code; pulls of port 1 and of absent port 0, then uplink
    task automatic t_modes(input logic [7:0] p0_mii);
        logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
        logic [7:0] pulls [4] = '{8'hC7, 8'h00, 8'hE0, 8'hFF};
        logic [3:0] masks [4] = '{4'h3, 4'hF, 4'h1, 4'h0};
        logic [3:0] rx;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h00, {22'h0, codes[i] == 2'h1 ? 2'h3 : 2'h0, {4{codes[i]}}});
            repeat (2) @(negedge ref_clk);
            chk({acc_pad_o[1].pu_rxd, acc_pad_o[1].pu_crs_dv, acc_pad_o[1].pu_txclk,
                 acc_pad_o[1].pu_rxclk, acc_pad_o[1].pd_col, acc_pad_o[1].txen_oe},
                {pulls[i], 1'b1});
            if (codes[i] == 2'h1) begin
                chk({acc_pad_o[0].pu_rxd, acc_pad_o[0].pu_crs_dv, acc_pad_o[0].pu_txclk,
                     acc_pad_o[0].pu_rxclk, acc_pad_o[0].pd_col}, p0_mii);
            end
            chk({up_pad_o.pu_rxd, up_pad_o.pu_rxdv, up_pad_o.pu_rxclk, up_pad_o.pu_ref_clk,
                 up_pad_o.pu_tx_clock, up_pad_o.pd_crs, up_pad_o.pd_col, up_pad_o.txen_oe},
                codes[i] == 2'h1 ? 11'h001 : 11'h7FE);
            rx = acc_pad_i[1].rxd;
            @(negedge ref_clk);
            chk(acc_mac_rx[1].rxd, rx & masks[i]);
        end
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog well beyond the expected hundred or so cycles
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    // Main sequence: detect on with port 0 absent, then detect off
    initial begin
        rst_n = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        t_straps(16'hFBFF, 4'hA, 5'b11110);
        t_modes(8'hFF);
        t_straps(16'hE107, 4'h5, 5'b11110);
        t_modes(8'h00);
        conclude();
    end
endmodule
